// >>> matd_defs.svh
// Register indices, field positions, reset values and limits of the activity detector
`ifndef MATD_DEFS_SVH
`define MATD_DEFS_SVH

`define MATD_IDX_SCTL 8'h10
`define MATD_IDX_CTRL 8'h13
`define MATD_IDX_CFG 8'h14
`define MATD_IDX_STATUS 8'h15
`define MATD_IDX_MASK 8'h16

`define MATD_SCTL_EN 0
`define MATD_SCTL_PD_LO 4
`define MATD_SCTL_PD_HI 6
`define MATD_CTRL_MODE 7
`define MATD_CTRL_COMB 6
`define MATD_CTRL_VAL_HI 5
`define MATD_CFG_RST 7
`define MATD_CFG_MUX_HI 6
`define MATD_CFG_MUX_LO 4
`define MATD_CFG_CNTEN 3
`define MATD_CFG_SEL_HI 2
`define MATD_STAT_WAKE 0
`define MATD_STAT_AX_LO 1
`define MATD_STAT_AX_HI 3

`define MATD_RST_SCTL 8'h00
`define MATD_RST_CTRL 2'h0
`define MATD_RST_CFG 8'h00
`define MATD_RST_STATUS 4'h0
`define MATD_RST_MASK 4'h0
`define MATD_RST_HIDDEN 6'h00

`define MATD_SEL_NONE_LO 3'h0
`define MATD_SEL_NONE_HI 3'h4
`define MATD_MUX_MAX 3'h5
`define MATD_DELTA_MAX 11'h7ff
`define MATD_CNT_MAX 6'h3f

`endif

// >>> matd_pkg.sv
// Types shared by the activity detector
package matd_pkg;
  typedef enum logic {MATD_COMB_OR, MATD_COMB_AND} matd_comb_t;
  typedef enum logic {MATD_DELTA_PREV, MATD_DELTA_BASE} matd_method_t;
  typedef logic [5:0] matd_hval_t;
  typedef logic signed [11:0] matd_smp_t;
endpackage

// >>> matd_top.sv
// Three-axis activity threshold detector with AHB-Lite register slave
//
// Summary of operation
// RQ1 - Each active axis forms a delta per sample and detects only when it is strictly above its threshold.
// RQ2 - Every axis has its own threshold and may need several detections before its wake flag sets.
// RQ3 - Six hidden values sit behind the low six bits of the control register, picked by a 3-bit selector.
// RQ4 - Selector 1..3 pick the X/Y/Z thresholds, 5..7 the X/Y/Z counts, and 0 and 4 pick nothing.
// RQ5 - Each threshold is an unsigned 6-bit value applied only to its own axis.
// RQ6 - Each count holds the wanted number of events minus one, so zero means a single event.
// RQ7 - Control bit 6 picks OR (0, reset) or AND (1) combining of the axis wake flags.
// RQ8 - In OR combining the wakeup rises as soon as any active axis has met threshold and count.
// RQ9 - In AND combining the wakeup rises only when all active axes have met threshold and count.
// RQ10 - An axis whose power-down bit is set takes no part in the combination.
// RQ11 - Control bit 7 at 0 takes the delta against the previous sample.
// RQ12 - Control bit 7 at 1 keeps the first sample after entering watch mode as baseline for the delta.
// RQ13 - The low six control bits read and write the hidden value that the selector points at.
// RQ14 - A 3-bit window picks six bits of the 11-bit delta, and a delta above the window still detects.
// RQ15 - A manual reset bit that software sets and clears re-arms the detector after a wakeup.
// RQ16 - The delta is a magnitude and a per-axis counter sets the axis flag once it passes the count.
// RQ17 - All control bits and hidden values reset to zero.
`include "matd_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module matd_top
  import matd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sample_valid,
  input wire logic [11:0] sample_x,
  input wire logic [11:0] sample_y,
  input wire logic [11:0] sample_z,
  output logic wakeup,
  output logic irq
);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus state
  logic wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // Software state
  logic [7:0] sctl_r;
  logic [1:0] ctrl_r;
  logic [7:0] cfg_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [5:0][5:0] hidden_r;

  // Detector state
  logic [2:0][11:0] prev_r;
  logic [2:0][11:0] base_r;
  logic [2:0][5:0] cnt_r;
  logic [2:0] flag_r;
  logic first_r;
  logic wake_r;
  logic irq_r;

  // Address phase decode
  wire logic take = hsel && hready && htrans[1];
  wire logic take_rd = take && !hwrite;
  wire logic take_wr = take && hwrite;
  wire logic [7:0] a_idx = haddr[9:2];

  // Data phase write strobes
  wire logic wr_sctl = wr_pend_r && (wr_idx_r == `MATD_IDX_SCTL);
  wire logic wr_ctrl = wr_pend_r && (wr_idx_r == `MATD_IDX_CTRL);
  wire logic wr_cfg = wr_pend_r && (wr_idx_r == `MATD_IDX_CFG);
  wire logic wr_stat = wr_pend_r && (wr_idx_r == `MATD_IDX_STATUS);
  wire logic wr_mask = wr_pend_r && (wr_idx_r == `MATD_IDX_MASK);

  // Configuration fields
  wire logic watch_en = sctl_r[`MATD_SCTL_EN];
  wire logic [2:0] pd = sctl_r[`MATD_SCTL_PD_HI:`MATD_SCTL_PD_LO];
  wire matd_method_t method = matd_method_t'(ctrl_r[1]);
  wire matd_comb_t comb = matd_comb_t'(ctrl_r[0]);
  wire logic [2:0] sel = cfg_r[`MATD_CFG_SEL_HI:0];
  wire logic [2:0] mux = cfg_r[`MATD_CFG_MUX_HI:`MATD_CFG_MUX_LO];
  wire logic cnten = cfg_r[`MATD_CFG_CNTEN];
  wire logic sniff_rst = cfg_r[`MATD_CFG_RST];
  wire logic [2:0] shift = (mux > `MATD_MUX_MAX) ? `MATD_MUX_MAX : mux; // RQ14

  // Hidden value selection: 1..3 thresholds, 5..7 counts, 0 and 4 nothing
  wire logic sel_none = (sel == `MATD_SEL_NONE_LO) || (sel == `MATD_SEL_NONE_HI); // RQ4
  wire logic [2:0] hid_idx = sel[2] ? (3'(sel[1:0]) + 3'h2) : (3'(sel[1:0]) - 3'h1); // RQ3
  wire logic [5:0] hid_rd = sel_none ? 6'h00 : hidden_r[hid_idx]; // RQ13

  // Samples and per-axis settings
  wire logic [2:0][11:0] smp = {sample_z, sample_y, sample_x};
  wire logic [2:0][5:0] thr = {hidden_r[2], hidden_r[1], hidden_r[0]}; // RQ5
  wire logic [2:0][5:0] cval = {hidden_r[5], hidden_r[4], hidden_r[3]}; // RQ6

  // Detection is held off on the baseline sample and while re-arming
  wire logic clr = !watch_en || sniff_rst; // RQ15
  wire logic run = sample_valid && watch_en && !first_r && !sniff_rst;

  logic [2:0] det;
  logic [2:0] hit;
  logic [2:0] flag_nxt;
  logic [2:0][5:0] cnt_nxt;
  logic [2:0][11:0] prev_nxt;
  logic [2:0][11:0] base_nxt;

  for (genvar i = 0; i < 3; i++)
  begin : g_axis
    wire logic [11:0] refv = (method == MATD_DELTA_BASE) ? base_r[i] : prev_r[i]; // RQ11 RQ12
    wire logic signed [12:0] diff = $signed({smp[i][11], smp[i]}) - $signed({refv[11], refv});
    // Magnitude saturates to the 11-bit delta range
    wire logic [12:0] mag = diff[12] ? 13'(-diff) : 13'(diff); // RQ16
    wire logic [10:0] dlt = (mag > 13'(`MATD_DELTA_MAX)) ? `MATD_DELTA_MAX : mag[10:0];
    wire logic [10:0] shd = dlt >> shift; // RQ14
    wire logic ovf = |shd[10:6]; // RQ14
    wire logic reached = !cnten || (cnt_r[i] >= cval[i]); // RQ2 RQ6 RQ16
    assign det[i] = ovf || (shd[5:0] > thr[i]); // RQ1
    assign hit[i] = run && det[i]; // RQ1
    assign flag_nxt[i] = clr ? 1'b0 : (flag_r[i] || (hit[i] && reached)); // RQ2 RQ15
    // Counter stops at its top so that it cannot wrap back below the count
    assign cnt_nxt[i] = clr ? 6'h00 :
                        (hit[i] && (cnt_r[i] != `MATD_CNT_MAX)) ? 6'(cnt_r[i] + 6'h01) : cnt_r[i]; // RQ16
    assign prev_nxt[i] = (sample_valid && watch_en) ? smp[i] : prev_r[i]; // RQ11
    assign base_nxt[i] = (sample_valid && watch_en && first_r) ? smp[i] : base_r[i]; // RQ12
  end

  // Combining of the axis flags, powered-down axes left out
  wire logic [2:0] act = ~pd; // RQ10
  wire logic or_wake = |(flag_r & act); // RQ8 RQ10
  wire logic and_wake = (|act) && (&(flag_r | pd)); // RQ9 RQ10
  wire logic wake_nxt = (comb == MATD_COMB_AND) ? and_wake : or_wake; // RQ7

  // Sticky events; a set in the clearing cycle wins
  wire logic [3:0] ev_set = {flag_nxt & ~flag_r, wake_nxt && !wake_r};
  wire logic [3:0] ev_clr = wr_stat ? hwdata[3:0] : 4'h0;
  wire logic [3:0] status_nxt = (status_r & ~ev_clr) | ev_set;

  // Read mux; reserved bits read as zero
  wire logic [31:0] rd_sctl = {24'h0, sctl_r};
  wire logic [31:0] rd_ctrl = {24'h0, ctrl_r, hid_rd}; // RQ13
  wire logic [31:0] rd_cfg = {24'h0, cfg_r};
  wire logic [31:0] rd_stat = {28'h0, status_r};
  wire logic [31:0] rd_mask = {28'h0, mask_r};
  wire logic [31:0] rd_mux = (a_idx == `MATD_IDX_SCTL) ? rd_sctl :
                             (a_idx == `MATD_IDX_CTRL) ? rd_ctrl :
                             (a_idx == `MATD_IDX_CFG) ? rd_cfg :
                             (a_idx == `MATD_IDX_STATUS) ? rd_stat :
                             (a_idx == `MATD_IDX_MASK) ? rd_mask : 32'h0;

  // Bus slave: not ready in reset, ready from the first clock after reset, read data registered at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hrdata_r <= 32'h0;
      hreadyout_r <= 1'b0;
      hresp_r <= 1'b0;
    end
    else
    begin
      wr_pend_r <= take_wr;
      wr_idx_r <= take_wr ? a_idx : wr_idx_r;
      hrdata_r <= take_rd ? rd_mux : 32'h0;
      hreadyout_r <= 1'b1;
      // Every transfer is answered OKAY, unmapped ones included
      hresp_r <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sctl_r <= `MATD_RST_SCTL; // RQ17
      ctrl_r <= `MATD_RST_CTRL; // RQ17
      cfg_r <= `MATD_RST_CFG; // RQ17
      mask_r <= `MATD_RST_MASK;
      status_r <= `MATD_RST_STATUS;
    end
    else
    begin
      sctl_r <= wr_sctl ? {1'b0, hwdata[6:4], 3'h0, hwdata[0]} : sctl_r;
      ctrl_r <= wr_ctrl ? hwdata[7:6] : ctrl_r; // RQ7 RQ11
      cfg_r <= wr_cfg ? hwdata[7:0] : cfg_r;
      mask_r <= wr_mask ? hwdata[3:0] : mask_r;
      status_r <= status_nxt;
    end
  end

  // Hidden values, written through the control register's low field
  for (genvar k = 0; k < 6; k++)
  begin : g_hidden
    wire logic hit_k = wr_ctrl && !sel_none && (hid_idx == 3'(k)); // RQ3 RQ4 RQ13
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        hidden_r[k] <= `MATD_RST_HIDDEN; // RQ17
      else if (hit_k)
        hidden_r[k] <= hwdata[`MATD_CTRL_VAL_HI:0];
    end
  end

  // Detector pipeline
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_r <= '0;
      base_r <= '0;
      cnt_r <= '0;
      flag_r <= 3'h0;
      first_r <= 1'b1;
      wake_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      prev_r <= prev_nxt;
      base_r <= base_nxt;
      cnt_r <= cnt_nxt;
      flag_r <= flag_nxt;
      // First sample after watch mode starts is the baseline
      first_r <= !watch_en || (first_r && !sample_valid); // RQ12
      wake_r <= wake_nxt;
      irq_r <= |(status_r & mask_r);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign wakeup = wake_r;
  assign irq = irq_r;

  // Checks
  detect_flag_a: assert property (hit[0] && !cnten && !clr |=> flag_r[0]) // RQ1
    else $error("axis detection without count did not set flag");
  no_detect_a: assert property (run && !det[1] && !flag_r[1] |=> !flag_r[1]) // RQ5
    else $error("flag set without delta above threshold");
  count_gate_a: assert property (hit[0] && cnten && (cnt_r[0] < cval[0]) && !flag_r[0] |=> !flag_r[0]) // RQ6
    else $error("flag set before detection count reached");
  hidden_wr_a: assert property (wr_ctrl && (sel == 3'h5) |=> hidden_r[3] == $past(hwdata[5:0])) // RQ13
    else $error("write through control did not reach selected value");
  null_sel_a: assert property (wr_ctrl && sel_none |=> $stable(hidden_r)) // RQ4
    else $error("null selector changed a hidden value");
  or_comb_a: assert property ((comb == MATD_COMB_OR) && (|(flag_r & ~pd)) |=> wakeup) // RQ8
    else $error("OR combining missed an active flag");
  and_comb_a: assert property ((comb == MATD_COMB_AND) && !(&(flag_r | pd)) |=> !wakeup) // RQ9
    else $error("AND combining woke with an active axis unmet");
  pd_excl_a: assert property ((comb == MATD_COMB_OR) && ((flag_r & ~pd) == 3'h0) |=> !wakeup) // RQ10
    else $error("powered-down axis took part in combining");
  base_hold_a: assert property (!(first_r && sample_valid) |=> $stable(base_r)) // RQ12
    else $error("baseline moved after capture");
  rearm_a: assert property (sniff_rst |=> (flag_r == 3'h0) && (cnt_r == '0) ##1 !wakeup) // RQ15
    else $error("manual reset did not clear detector");
  irq_level_a: assert property ((|(status_r & mask_r)) |=> irq)
    else $error("unmasked status did not raise interrupt");
  irq_low_a: assert property (!(|(status_r & mask_r)) |=> !irq)
    else $error("interrupt high with no unmasked status");

  // Bus side
  bus_ready_a: assert property (hresetn |=> hreadyout)
    else $error("slave not ready after reset");
  rd_data_a: assert property (take_rd |=> hrdata == $past(rd_mux))
    else $error("read data not presented in data phase");
  rd_idle_a: assert property (!take_rd |=> hrdata == 32'h0)
    else $error("read data left standing outside data phase");
  sctl_wr_a: assert property (wr_sctl |=> sctl_r == {1'b0, $past(hwdata[6:4]), 3'h0, $past(hwdata[0])}) // RQ10
    else $error("sample control write lost");
  sctl_hold_a: assert property (!wr_sctl |=> $stable(sctl_r))
    else $error("sample control changed without write");
  ctrl_wr_a: assert property (wr_ctrl |=> ctrl_r == $past(hwdata[7:6])) // RQ7
    else $error("control mode bits write lost");
  ctrl_hold_a: assert property (!wr_ctrl |=> $stable(ctrl_r)) // RQ11
    else $error("control mode bits changed without write");
  cfg_wr_a: assert property (wr_cfg |=> cfg_r == $past(hwdata[7:0]))
    else $error("config write lost");
  cfg_hold_a: assert property (!wr_cfg |=> $stable(cfg_r))
    else $error("config changed without write");
  mask_wr_a: assert property (wr_mask |=> mask_r == $past(hwdata[3:0]))
    else $error("mask write lost");
  mask_hold_a: assert property (!wr_mask |=> $stable(mask_r))
    else $error("mask changed without write");

  // Hidden values reached through the selector
  hid_x_a: assert property (wr_ctrl && (sel == 3'h1) |=> hidden_r[0] == $past(hwdata[5:0])) // RQ3
    else $error("X threshold not written through control");
  hid_y_a: assert property (wr_ctrl && (sel == 3'h2) |=> hidden_r[1] == $past(hwdata[5:0])) // RQ3
    else $error("Y threshold not written through control");
  hid_z_a: assert property (wr_ctrl && (sel == 3'h3) |=> hidden_r[2] == $past(hwdata[5:0])) // RQ3
    else $error("Z threshold not written through control");
  hid_ycnt_a: assert property (wr_ctrl && (sel == 3'h6) |=> hidden_r[4] == $past(hwdata[5:0])) // RQ4
    else $error("Y count not written through control");
  hid_zcnt_a: assert property (wr_ctrl && (sel == 3'h7) |=> hidden_r[5] == $past(hwdata[5:0])) // RQ4
    else $error("Z count not written through control");
  hid_hold_a: assert property (!wr_ctrl |=> $stable(hidden_r)) // RQ13
    else $error("hidden value changed without control write");

  // Detector
  prev_cap_a: assert property (sample_valid && watch_en |=> prev_r == $past(smp)) // RQ11
    else $error("previous sample not captured");
  prev_hold_a: assert property (!sample_valid |=> $stable(prev_r)) // RQ11
    else $error("previous sample moved without a sample");
  base_cap_a: assert property (sample_valid && watch_en && first_r |=> base_r == $past(smp)) // RQ12
    else $error("baseline not captured on first sample");
  first_clr_a: assert property (sample_valid && watch_en |=> !first_r) // RQ12
    else $error("baseline marker not cleared by a sample");
  cnt_step_a: assert property (hit[2] && !clr && (cnt_r[2] != `MATD_CNT_MAX) |=> cnt_r[2] == $past(cnt_r[2]) + 6'h01) // RQ16
    else $error("detection counter did not advance");
  cnt_sat_a: assert property ((cnt_r[1] == `MATD_CNT_MAX) && !clr |=> cnt_r[1] == `MATD_CNT_MAX) // RQ16
    else $error("detection counter wrapped");
  flag_keep_a: assert property (flag_r[2] && !clr |=> flag_r[2]) // RQ2
    else $error("axis flag dropped while armed");
  watch_off_a: assert property (!watch_en |=> (flag_r == 3'h0) && (cnt_r == '0))
    else $error("watch disable did not clear detector");
  and_none_a: assert property ((comb == MATD_COMB_AND) && (pd == 3'h7) |=> !wakeup) // RQ10
    else $error("AND combining woke with every axis powered down");

  // Sticky status: a set in the clearing cycle must survive
  status_set_a: assert property ((|ev_set) |=> (status_r & $past(ev_set)) == $past(ev_set))
    else $error("status event lost");
  status_clr_a: assert property (wr_stat && (ev_set == 4'h0) |=> (status_r & $past(hwdata[3:0])) == 4'h0)
    else $error("status bit not cleared by writing one");

  wake_or_c: cover property ((comb == MATD_COMB_OR) && $rose(wakeup));
  wake_and_c: cover property ((comb == MATD_COMB_AND) && $rose(wakeup));
  base_det_c: cover property ((method == MATD_DELTA_BASE) && hit[2]);
  multi_cnt_c: cover property (cnten && (cval[0] != 6'h00) && $rose(flag_r[0]));
  rearm_c: cover property (sniff_rst && (flag_r != 3'h0));

endmodule

`default_nettype wire

// >>> matd_host.sv
// Bus master model standing in for host software
`timescale 1ns/1ps
`default_nettype none
module matd_host (
  input wire logic hclk,
  input wire logic hready,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_ph,
  output logic tmo
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_ph = 1'b0;
    tmo = 1'b0;
  end
  // Bounded wait for hready; a hang raises tmo for the bench
  task automatic wt();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge hclk);
    end
    if (n == 50)
      tmo <= 1'b1;
  endtask
  // Single word transfer, then one idle cycle so a read never sees a pre-write value
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wt();
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    rd_ph <= !w;
    wt();
    rd_ph <= 1'b0;
    @(posedge hclk);
  endtask
endmodule
`default_nettype wire

// >>> motion_activity_threshold_detector_tb_top.sv
// Self-checking bench for the activity threshold detector
`include "matd_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module motion_activity_threshold_detector_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic sample_valid = 1'b0;
  logic [11:0] sx = 12'h0, sy = 12'h0, sz = 12'h0, b = 12'h0;
  logic [31:0] haddr, hwdata, hrdata, rs = 32'hef7c;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hsel, hwrite, hreadyout, hresp, wakeup, irq, rd_ph, tmo;
  logic [7:0] cfgb, ctrlb;
  logic [31:0] expq[$];
  int error_cnt = 0;
  int checks_done = 0;
  always #5 hclk = ~hclk;
  matd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sample_valid(sample_valid), .sample_x(sx), .sample_y(sy), .sample_z(sz), .wakeup(wakeup), .irq(irq));
  matd_host host (.hclk(hclk), .hready(hreadyout), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .rd_ph(rd_ph), .tmo(tmo));
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Read data is taken at the edge that ends the data phase
  always @(posedge hclk)
    if (rd_ph === 1'b1)
    begin
      ck(hrdata, expq.pop_front());
      ck({31'h0, hresp}, 32'h0);
    end
  always @(posedge tmo)
  begin
    error_cnt++;
    complete_run();
  end
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    host.xfer(i, 1'b1, d);
  endtask
  task automatic rdx(input logic [7:0] i, input logic [31:0] e);
    expq.push_back(e);
    host.xfer(i, 1'b0, 32'h0);
  endtask
  // Pin is read after the waits, once the edge's updates have settled; w picks irq, else wakeup
  task automatic ckpin(input bit w, input logic e);
    repeat (2) @(posedge hclk);
    #1;
    ck({31'h0, w ? irq : wakeup}, {31'h0, e});
    @(posedge hclk);
  endtask
  task automatic setv(input logic [2:0] s, input logic [5:0] v);
    wr(`MATD_IDX_CFG, {24'h0, cfgb | {5'h0, s}});
    wr(`MATD_IDX_CTRL, {24'h0, ctrlb | {2'b00, v}});
  endtask
  task automatic smp(input int dx, input int dy, input int dz);
    sample_valid <= 1'b1;
    sx <= b + 12'(dx);
    sy <= b + 12'(dy);
    sz <= b + 12'(dz);
    @(posedge hclk);
    sample_valid <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
  // Watch off clears flags, so every test starts from a fresh reference sample
  task automatic arm(input logic [7:0] sc);
    wr(`MATD_IDX_SCTL, 32'h0);
    wr(`MATD_IDX_STATUS, 32'hf);
    wr(`MATD_IDX_SCTL, {24'h0, sc});
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    b = {2'b00, rs[9:0]} - 12'h200;
    smp(0, 0, 0);
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    for (int k = 0; k < 6; k++)
      rdx(8'(k + 16), 32'h0);
    wr(8'h20, 32'hffff);
    rdx(8'h20, 32'h0);
    ckpin(1'b0, 1'b0);
    $display("test reset done");
    cfgb = 8'h00;
    ctrlb = 8'h00;
    for (int s = 0; s < 8; s++)
      setv(3'(s), 6'(s * 7 + 3));
    for (int s = 0; s < 8; s++)
    begin
      wr(`MATD_IDX_CFG, 32'(s));
      rdx(`MATD_IDX_CTRL, (s % 4 == 0) ? 32'h0 : 32'(s * 7 + 3));
    end
    setv(1, 10);
    setv(2, 20);
    setv(3, 30);
    for (int s = 5; s < 8; s++)
      setv(3'(s), 0);
    setv(0, 0);
    $display("test hidden done");
    arm(8'h01);
    smp(10, 20, 30);
    smp(0, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h0);
    smp(11, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h3);
    ckpin(1'b1, 1'b0);
    wr(`MATD_IDX_MASK, 32'h1);
    ckpin(1'b1, 1'b1);
    wr(`MATD_IDX_STATUS, 32'h1);
    ckpin(1'b1, 1'b0);
    rdx(`MATD_IDX_STATUS, 32'h2);
    $display("test or done");
    ctrlb = 8'h40;
    setv(0, 0);
    arm(8'h21);
    smp(11, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h2);
    ckpin(1'b0, 1'b0);
    smp(11, 0, 31);
    rdx(`MATD_IDX_STATUS, 32'hb);
    ckpin(1'b0, 1'b1);
    $display("test and done");
    ctrlb = 8'h80;
    cfgb = 8'h08;
    setv(5, 1);
    setv(0, 0);
    arm(8'h01);
    smp(11, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h0);
    smp(11, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h3);
    $display("test count done");
    ctrlb = 8'h00;
    cfgb = 8'h20;
    setv(5, 0);
    setv(0, 0);
    arm(8'h01);
    smp(40, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h0);
    smp(84, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h3);
    cfgb = 8'h00;
    setv(1, 63);
    setv(0, 0);
    arm(8'h01);
    smp(64, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h3);
    wr(`MATD_IDX_CFG, 32'h80);
    wr(`MATD_IDX_STATUS, 32'hf);
    smp(0, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h0);
    wr(`MATD_IDX_CFG, 32'h0);
    smp(64, 0, 0);
    rdx(`MATD_IDX_STATUS, 32'h3);
    $display("test window done");
    repeat (3) @(posedge hclk);
    complete_run();
  end
endmodule
`default_nettype wire
